// >>> pkg/rph_pkg.sv
package rph_pkg;

  // ----------------------------------------
  // Register indices and byte addresses
  // ----------------------------------------
  localparam int ADDR_W = 18;
  localparam logic [15:0] IDX_SYNC_HI = 16'hdf00;
  localparam logic [15:0] IDX_SYNC_LO = 16'hdf01;
  localparam logic [15:0] IDX_PKT_LEN = 16'hdf02;
  localparam logic [15:0] IDX_CTRL1 = 16'hdf03;
  localparam logic [15:0] IDX_CTRL0 = 16'hdf04;
  localparam logic [15:0] IDX_STATION = 16'hdf05;
  localparam logic [15:0] IDX_CHANNEL = 16'hdf06;
  localparam logic [15:0] IDX_DEBUG0 = 16'hdf31;
  localparam logic [15:0] IDX_STATUS = 16'hdf40;

  // ----------------------------------------
  // Reset values and writable bits
  // ----------------------------------------
  localparam logic [7:0] RST_SYNC_HI = 8'hd3;
  localparam logic [7:0] RST_SYNC_LO = 8'h91;
  localparam logic [7:0] RST_PKT_LEN = 8'hff;
  localparam logic [7:0] RST_CTRL1 = 8'h04;
  localparam logic [7:0] RST_CTRL0 = 8'h45;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] WMASK_CTRL1 = 8'he7;
  localparam logic [7:0] WMASK_CTRL0 = 8'h7f;
  localparam logic [7:0] WMASK_DEBUG = 8'h7f;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int PQ_THR_HI = 7;
  localparam int PQ_THR_LO = 5;
  localparam int APPEND_BIT = 2;
  localparam int ADRCHK_HI = 1;
  localparam int ADRCHK_LO = 0;
  localparam int WHITE_BIT = 6;
  localparam int FMT_HI = 5;
  localparam int FMT_LO = 4;
  localparam int LEGACY_BIT = 3;
  localparam int CRCEN_BIT = 2;
  localparam int LENCFG_HI = 1;
  localparam int LENCFG_LO = 0;
  localparam int DBG_INV_BIT = 6;
  localparam int DBG_SEL_HI = 5;

  // ----------------------------------------
  // Codes and constants
  // ----------------------------------------
  localparam logic [1:0] ADR_NONE = 2'b00;
  localparam logic [1:0] ADR_BC0 = 2'b10;
  localparam logic [1:0] ADR_BC01 = 2'b11;
  localparam logic [1:0] FMT_RANDOM = 2'b10;
  localparam logic [1:0] LEN_VARIABLE = 2'b01;
  localparam logic [7:0] BCAST_LOW = 8'h00;
  localparam logic [7:0] BCAST_HIGH = 8'hff;
  localparam logic [8:0] PN9_SEED = 9'h1ff;
  localparam logic [15:0] CRC_POLY = 16'h8005;
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_INIT_LEGACY = 16'h0000;
  localparam logic [4:0] PQ_MAX = 5'h1f;
  localparam logic [4:0] PQ_DOWN = 5'h08;
  localparam logic [7:0] CRC_BYTES = 8'h02;
  localparam logic [5:0] SEL_IN_PACKET = 6'h00;
  localparam logic [5:0] SEL_PQ_OK = 6'h01;
  localparam logic [5:0] SEL_CRC_OK = 6'h02;
  localparam logic [5:0] SEL_TX_BIT = 6'h03;
  localparam logic [5:0] SEL_RX_BIT = 6'h04;
  localparam logic [5:0] SEL_PKT_DONE = 6'h05;

  typedef enum logic [3:0] {
    RX_HUNT, RX_LEN, RX_ADDR, RX_DATA, RX_CRC, RX_CHK, RX_ST1, RX_ST2, RX_DONE
  } rph_rx_state_t;

  typedef struct packed {
    logic [7:0] sync_hi;
    logic [7:0] sync_lo;
    logic [7:0] pkt_len;
    logic [7:0] ctrl1;
    logic [7:0] ctrl0;
    logic [7:0] station;
    logic [7:0] channel;
    logic [7:0] debug0;
  } rph_cfg_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } rph_rx_byte_t;

endpackage

// >>> src/rph_crc16.sv
`timescale 1ns/1ps
module rph_crc16 import rph_pkg::*; (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic init,
  input wire logic legacy,
  input wire logic bit_valid,
  input wire logic bit_in,
  output logic [15:0] crc
);
  logic [15:0] crc_reg, crc_next;
  logic fb;

  // Feeding the current top bit back in turns the register into a plain shifter,
  // which is how the transmitter streams out the finished checksum.
  always_comb begin
    fb = bit_in ^ crc_reg[15];
    crc_next = crc_reg;
    if (init) begin
      crc_next = legacy ? CRC_INIT_LEGACY : CRC_INIT;
    end else if (bit_valid) begin
      crc_next = {crc_reg[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      crc_reg <= CRC_INIT;
    end else begin
      crc_reg <= crc_next;
    end
  end

  assign crc = crc_reg;
endmodule

// >>> src/rph_packet_handler.sv
// Local design decision: the AHB-Lite register port.
`timescale 1ns/1ps
module rph_packet_handler import rph_pkg::*; (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic rx_bit_valid,
  input wire logic rx_bit,
  input wire logic [7:0] rssi,
  input wire logic [6:0] lqi,
  output rph_rx_byte_t rx_out,
  output logic pkt_done,
  output logic crc_ok,
  input wire logic tx_start,
  input wire logic tx_bit_req,
  input wire logic tx_data_bit,
  input wire logic tx_crc_sel,
  output logic tx_bit,
  input wire logic [23:0] base_freq,
  input wire logic [15:0] channel_spacing,
  output logic [23:0] freq_word,
  output logic debug_port_pin
);

  // ----------------------------------------
  // Register bus and configuration
  // ----------------------------------------
  rph_cfg_t cfg_reg, cfg_next;
  logic wr_reg, wr_next, rd_reg, rd_next;
  logic [15:0] idx_reg, idx_next;
  logic hreadyout_reg, hreadyout_next;
  logic [31:0] hrdata_reg, hrdata_next;
  logic [7:0] rd_mux, status_byte;
  logic ap;
  logic [4:0] pq_count;
  logic pq_ok;
  rph_rx_state_t state_reg, state_next;
  logic crc_ok_reg, crc_ok_next;

  logic [2:0] preamble_quality_threshold;
  logic append_en, white_en, legacy_en, crc_en, fmt_random, len_variable;
  logic [1:0] adr_mode;
  assign preamble_quality_threshold = cfg_reg.ctrl1[PQ_THR_HI:PQ_THR_LO];
  assign append_en = cfg_reg.ctrl1[APPEND_BIT];
  assign adr_mode = cfg_reg.ctrl1[ADRCHK_HI:ADRCHK_LO];
  assign white_en = cfg_reg.ctrl0[WHITE_BIT];
  assign legacy_en = cfg_reg.ctrl0[LEGACY_BIT];
  assign crc_en = cfg_reg.ctrl0[CRCEN_BIT];
  assign fmt_random = (cfg_reg.ctrl0[FMT_HI:FMT_LO] == FMT_RANDOM);
  assign len_variable = (cfg_reg.ctrl0[LENCFG_HI:LENCFG_LO] == LEN_VARIABLE);

  assign status_byte = {crc_ok_reg, (state_reg != RX_HUNT), pq_ok, pq_count};

  always_comb begin
    case (idx_reg)
      IDX_SYNC_HI: rd_mux = cfg_reg.sync_hi;
      IDX_SYNC_LO: rd_mux = cfg_reg.sync_lo;
      IDX_PKT_LEN: rd_mux = cfg_reg.pkt_len;
      IDX_CTRL1: rd_mux = cfg_reg.ctrl1;
      IDX_CTRL0: rd_mux = cfg_reg.ctrl0;
      IDX_STATION: rd_mux = cfg_reg.station;
      IDX_CHANNEL: rd_mux = cfg_reg.channel;
      IDX_DEBUG0: rd_mux = cfg_reg.debug0;
      IDX_STATUS: rd_mux = status_byte;
      default: rd_mux = 8'h00;
    endcase
  end

  // Reads take one wait state so that a write in the previous data phase is
  // already stored when the read data is captured.
  always_comb begin
    ap = hsel && htrans[1] && hready;
    wr_next = ap && hwrite;
    rd_next = ap && !hwrite;
    idx_next = ap ? haddr[ADDR_W-1:2] : idx_reg;
    hreadyout_next = !(ap && !hwrite);
    hrdata_next = rd_reg ? {24'h00_0000, rd_mux} : hrdata_reg;
    cfg_next = cfg_reg;
    if (wr_reg) begin
      case (idx_reg)
        IDX_SYNC_HI: cfg_next.sync_hi = hwdata[7:0];
        IDX_SYNC_LO: cfg_next.sync_lo = hwdata[7:0];
        IDX_PKT_LEN: cfg_next.pkt_len = hwdata[7:0];
        IDX_CTRL1: cfg_next.ctrl1 = hwdata[7:0] & WMASK_CTRL1;
        IDX_CTRL0: cfg_next.ctrl0 = hwdata[7:0] & WMASK_CTRL0;
        IDX_STATION: cfg_next.station = hwdata[7:0];
        IDX_CHANNEL: cfg_next.channel = hwdata[7:0];
        IDX_DEBUG0: cfg_next.debug0 = hwdata[7:0] & WMASK_DEBUG;
        default: cfg_next = cfg_reg;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_reg <= {RST_SYNC_HI, RST_SYNC_LO, RST_PKT_LEN, RST_CTRL1, RST_CTRL0, RST_ZERO, RST_ZERO, RST_ZERO};
      wr_reg <= 1'b0;
      rd_reg <= 1'b0;
      idx_reg <= 16'h0000;
      hreadyout_reg <= 1'b1;
      hrdata_reg <= 32'h0000_0000;
    end else begin
      cfg_reg <= cfg_next;
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      idx_reg <= idx_next;
      hreadyout_reg <= hreadyout_next;
      hrdata_reg <= hrdata_next;
    end
  end

  assign hreadyout = hreadyout_reg;
  assign hresp = 1'b0;
  assign hrdata = hrdata_reg;

  // ----------------------------------------
  // Receive path
  // ----------------------------------------
  logic [15:0] sync_sh_reg, sync_sh_next, sync_cand, rx_crc;
  logic [7:0] sh_reg, sh_next, rem_reg, rem_next, byte_val;
  logic [2:0] bit_cnt_reg, bit_cnt_next;
  logic [8:0] rx_pn_reg, rx_pn_next;
  rph_rx_byte_t rx_out_reg, rx_out_next;
  logic pkt_done_reg, pkt_done_next;
  logic in_bytes, d, byte_done, sync_hit, addr_match;
  rph_rx_state_t tail;

  rph_preamble_quality u_pq (
    .hclk(hclk),
    .hresetn(hresetn),
    .bit_valid(rx_bit_valid),
    .bit_in(rx_bit),
    .threshold(preamble_quality_threshold),
    .count(pq_count),
    .pq_ok(pq_ok)
  );

  rph_crc16 u_rx_crc (
    .hclk(hclk),
    .hresetn(hresetn),
    .init(sync_hit),
    .legacy(legacy_en),
    .bit_valid(rx_bit_valid && in_bytes),
    .bit_in(d),
    .crc(rx_crc)
  );

  always_comb begin
    in_bytes = (state_reg == RX_LEN) || (state_reg == RX_ADDR) || (state_reg == RX_DATA) || (state_reg == RX_CRC);
    d = rx_bit ^ (white_en & rx_pn_reg[0]);
    byte_done = rx_bit_valid && in_bytes && (bit_cnt_reg == 3'd7);
    byte_val = {sh_reg[6:0], d};
    sync_cand = {sync_sh_reg[14:0], rx_bit};
    sync_hit = (state_reg == RX_HUNT) && rx_bit_valid && (sync_cand == {cfg_reg.sync_hi, cfg_reg.sync_lo})
               && pq_ok;
    addr_match = (byte_val == cfg_reg.station)
                 || ((adr_mode == ADR_BC0 || adr_mode == ADR_BC01) && byte_val == BCAST_LOW)
                 || ((adr_mode == ADR_BC01) && byte_val == BCAST_HIGH);
    tail = crc_en ? RX_CRC : RX_CHK;
    state_next = state_reg;
    sync_sh_next = sync_sh_reg;
    sh_next = sh_reg;
    rem_next = rem_reg;
    bit_cnt_next = bit_cnt_reg;
    rx_pn_next = rx_pn_reg;
    rx_out_next = '{valid: 1'b0, data: rx_out_reg.data};
    pkt_done_next = 1'b0;
    crc_ok_next = crc_ok_reg;
    if (rx_bit_valid && in_bytes) begin
      sh_next = byte_val;
      bit_cnt_next = bit_cnt_reg + 3'd1;
      rx_pn_next = {rx_pn_reg[5] ^ rx_pn_reg[0], rx_pn_reg[8:1]};
    end
    case (state_reg)
      RX_HUNT: begin
        if (rx_bit_valid) begin
          sync_sh_next = sync_cand;
        end
        if (sync_hit) begin
          bit_cnt_next = 3'd0;
          rx_pn_next = PN9_SEED;
          rem_next = cfg_reg.pkt_len;
          state_next = len_variable ? RX_LEN : ((adr_mode != ADR_NONE) ? RX_ADDR : RX_DATA);
        end
      end
      RX_LEN: if (byte_done) begin
        rem_next = byte_val;
        if (byte_val > cfg_reg.pkt_len || byte_val == 8'h00) begin
          state_next = RX_HUNT;
        end else begin
          rx_out_next = '{valid: 1'b1, data: byte_val};
          state_next = (adr_mode != ADR_NONE) ? RX_ADDR : RX_DATA;
        end
      end
      RX_ADDR: if (byte_done) begin
        if (addr_match) begin
          rx_out_next = '{valid: 1'b1, data: byte_val};
          rem_next = rem_reg - 8'd1;
          state_next = (rem_reg == 8'd1) ? tail : RX_DATA;
        end else begin
          state_next = RX_HUNT;
        end
      end
      RX_DATA: if (byte_done) begin
        rx_out_next = '{valid: 1'b1, data: byte_val};
        rem_next = (rem_reg == 8'd1) ? CRC_BYTES : rem_reg - 8'd1;
        state_next = (rem_reg == 8'd1) ? tail : RX_DATA;
      end
      RX_CRC: if (byte_done) begin
        rem_next = rem_reg - 8'd1;
        state_next = (rem_reg == 8'd1) ? RX_CHK : RX_CRC;
      end
      RX_CHK: begin
        crc_ok_next = !crc_en || (rx_crc == 16'h0000);
        state_next = append_en ? RX_ST1 : RX_DONE;
      end
      RX_ST1: begin
        rx_out_next = '{valid: 1'b1, data: rssi};
        state_next = RX_ST2;
      end
      RX_ST2: begin
        rx_out_next = '{valid: 1'b1, data: {crc_ok_reg, lqi}};
        state_next = RX_DONE;
      end
      RX_DONE: begin
        pkt_done_next = 1'b1;
        state_next = RX_HUNT;
      end
      default: state_next = RX_HUNT;
    endcase
    if (state_reg == RX_ADDR && byte_done && addr_match && rem_reg == 8'd1) begin
      rem_next = CRC_BYTES;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= RX_HUNT;
      sync_sh_reg <= 16'h0000;
      sh_reg <= 8'h00;
      rem_reg <= 8'h00;
      bit_cnt_reg <= 3'd0;
      rx_pn_reg <= PN9_SEED;
      rx_out_reg <= '0;
      pkt_done_reg <= 1'b0;
      crc_ok_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      sync_sh_reg <= sync_sh_next;
      sh_reg <= sh_next;
      rem_reg <= rem_next;
      bit_cnt_reg <= bit_cnt_next;
      rx_pn_reg <= rx_pn_next;
      rx_out_reg <= rx_out_next;
      pkt_done_reg <= pkt_done_next;
      crc_ok_reg <= crc_ok_next;
    end
  end

  assign rx_out = rx_out_reg;
  assign pkt_done = pkt_done_reg;
  assign crc_ok = crc_ok_reg;

  // ----------------------------------------
  // Transmit path, frequency and debug pin
  // ----------------------------------------
  logic [8:0] tx_pn_reg, tx_pn_next;
  logic tx_bit_reg, tx_bit_next, tx_raw, dbg_reg, dbg_next, dbg_sig;
  logic [15:0] tx_crc;
  logic [23:0] freq_reg, freq_next;

  rph_crc16 u_tx_crc (
    .hclk(hclk),
    .hresetn(hresetn),
    .init(tx_start),
    .legacy(legacy_en),
    .bit_valid(tx_bit_req && !fmt_random),
    .bit_in(tx_raw),
    .crc(tx_crc)
  );

  always_comb begin
    tx_raw = (tx_crc_sel && crc_en) ? tx_crc[15] : tx_data_bit;
    tx_pn_next = tx_pn_reg;
    tx_bit_next = tx_bit_reg;
    if (tx_start) begin
      tx_pn_next = PN9_SEED;
    end else if (tx_bit_req) begin
      tx_bit_next = fmt_random ? tx_pn_reg[0] : (tx_raw ^ (white_en & tx_pn_reg[0]));
      tx_pn_next = {tx_pn_reg[5] ^ tx_pn_reg[0], tx_pn_reg[8:1]};
    end
    // Both factors are widened to 24 bits so that the full product is kept before the add.
    freq_next = base_freq + ({16'h0000, cfg_reg.channel} * {8'h00, channel_spacing});
    case (cfg_reg.debug0[DBG_SEL_HI:0])
      SEL_IN_PACKET: dbg_sig = (state_reg != RX_HUNT);
      SEL_PQ_OK: dbg_sig = pq_ok;
      SEL_CRC_OK: dbg_sig = crc_ok_reg;
      SEL_TX_BIT: dbg_sig = tx_bit_reg;
      SEL_RX_BIT: dbg_sig = rx_bit;
      SEL_PKT_DONE: dbg_sig = pkt_done_reg;
      default: dbg_sig = 1'b0;
    endcase
    dbg_next = dbg_sig ^ cfg_reg.debug0[DBG_INV_BIT];
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_pn_reg <= PN9_SEED;
      tx_bit_reg <= 1'b0;
      freq_reg <= 24'h00_0000;
      dbg_reg <= 1'b0;
    end else begin
      tx_pn_reg <= tx_pn_next;
      tx_bit_reg <= tx_bit_next;
      freq_reg <= freq_next;
      dbg_reg <= dbg_next;
    end
  end

  assign tx_bit = tx_bit_reg;
  assign freq_word = freq_reg;
  assign debug_port_pin = dbg_reg;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  AST_DBG_POLARITY: assert property (
    cfg_reg.debug0[5:0] == SEL_CRC_OK |=> debug_port_pin == ($past(crc_ok_reg) ^ $past(cfg_reg.debug0[6])))
    else $error("Debug pin polarity wrong.");
  AST_DBG_UNUSED: assert property (
    cfg_reg.debug0[5:0] > SEL_PKT_DONE |=> debug_port_pin == $past(cfg_reg.debug0[6]))
    else $error("Unused selector code did not give idle level.");
  AST_SYNC_MATCH: assert property (
    state_reg == RX_HUNT && state_next != RX_HUNT |-> sync_cand == {cfg_reg.sync_hi, cfg_reg.sync_lo})
    else $error("Packet started without sync word match.");
  AST_LEN_LIMIT: assert property (
    state_reg == RX_LEN && byte_done && byte_val > cfg_reg.pkt_len |=> state_reg == RX_HUNT && !rx_out.valid)
    else $error("Over-long packet not dropped.");
  AST_PQ_GATE: assert property (
    sync_hit |-> preamble_quality_threshold == 3'd0
      || {1'b0, pq_count} >= {1'b0, preamble_quality_threshold, 2'b00})
    else $error("Sync accepted below preamble quality threshold.");
  AST_APPEND: assert property (
    state_reg == RX_CHK && append_en |=> rx_out.valid == 1'b0 ##1 rx_out.valid && rx_out.data == $past(rssi))
    else $error("Signal strength byte not appended.");
  AST_ADDR_DROP: assert property (
    state_reg == RX_ADDR && byte_done && !addr_match |=> state_reg == RX_HUNT)
    else $error("Mismatched address not dropped.");
  AST_ADDR_OWN: assert property (
    state_reg == RX_ADDR && byte_done && byte_val == cfg_reg.station |=> rx_out.valid)
    else $error("Own station address rejected.");
  AST_PN9_TX: assert property (
    fmt_random && tx_bit_req && !tx_start |=> tx_bit == $past(tx_pn_reg[0]))
    else $error("Random mode did not send PN9 bit.");
  AST_CRC_OFF: assert property (
    state_reg == RX_CHK && !crc_en |=> crc_ok_reg)
    else $error("CRC flag false with checking disabled.");
  AST_FIXED_LEN: assert property (
    sync_hit && !len_variable |=> rem_reg == $past(cfg_reg.pkt_len) && state_reg != RX_LEN)
    else $error("Fixed mode did not load packet length.");
  AST_FREQ: assert property (
    $past(hresetn) |-> freq_word == $past(base_freq)
      + ({16'h0000, $past(cfg_reg.channel)} * {8'h00, $past(channel_spacing)}))
    else $error("Frequency word wrong.");

  COV_PKT_DONE: cover property (pkt_done && crc_ok);
  COV_ADDR_DROP: cover property (state_reg == RX_ADDR ##1 state_reg == RX_HUNT);
  COV_READ: cover property (rd_reg ##1 hreadyout);
endmodule

// >>> src/rph_preamble_quality.sv
`timescale 1ns/1ps
module rph_preamble_quality import rph_pkg::*; (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic bit_valid,
  input wire logic bit_in,
  input wire logic [2:0] threshold,
  output logic [4:0] count,
  output logic pq_ok
);
  logic [4:0] cnt_reg, cnt_next;
  logic prev_reg, prev_next;
  logic ok_reg, ok_next;

  always_comb begin
    cnt_next = cnt_reg;
    prev_next = prev_reg;
    if (bit_valid) begin
      prev_next = bit_in;
      if (bit_in != prev_reg) begin
        cnt_next = (cnt_reg == PQ_MAX) ? cnt_reg : cnt_reg + 5'd1;
      end else begin
        cnt_next = (cnt_reg < PQ_DOWN) ? 5'd0 : cnt_reg - PQ_DOWN;
      end
    end
    ok_next = (threshold == 3'd0) || ({1'b0, cnt_next} >= {1'b0, threshold, 2'b00});
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_reg <= 5'd0;
      prev_reg <= 1'b0;
      ok_reg <= 1'b1;
    end else begin
      cnt_reg <= cnt_next;
      prev_reg <= prev_next;
      ok_reg <= ok_next;
    end
  end

  assign count = cnt_reg;
  assign pq_ok = ok_reg;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  AST_PQ_UP: assert property (@(posedge hclk) disable iff (!hresetn)
    bit_valid && bit_in != prev_reg && cnt_reg < PQ_MAX |=> cnt_reg == $past(cnt_reg) + 5'd1)
    else $error("Preamble counter did not step up by one.");
  AST_PQ_DOWN: assert property (@(posedge hclk) disable iff (!hresetn)
    bit_valid && bit_in == prev_reg && cnt_reg >= PQ_DOWN |=> cnt_reg == $past(cnt_reg) - PQ_DOWN)
    else $error("Preamble counter did not step down by eight.");
endmodule

// >>> test/rph_air_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Remote transmitter
// ----------------------------------------
module rph_air_model (
  input wire logic hclk,
  output logic bit_valid,
  output logic bit_out
);
  initial begin
    bit_valid = 1'b0;
    bit_out = 1'b0;
  end
  // Sends the top n bits of v, MSB first, one bit per cycle.
  // A released line shows the inverse of the last bit, so no stale value passes for data.
  task automatic send(input logic [127:0] v, input int n);
    for (int i = 127; i > 127 - n; i--) begin
      bit_valid <= 1'b1;
      bit_out <= v[i];
      @(posedge hclk);
    end
    bit_valid <= 1'b0;
    bit_out <= ~v[128-n];
  endtask
endmodule

// >>> test/testbench.sv
`timescale 1ns/1ps
module testbench import rph_pkg::*;;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, rx_bit_valid, rx_bit, pkt_done, crc_ok;
  logic tx_start, tx_bit_req, tx_data_bit, tx_crc_sel, tx_bit, debug_port_pin;
  logic [ADDR_W-1:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, rd;
  logic [7:0] rssi, last, prev;
  logic [6:0] lqi;
  logic [47:0] txw, pn;
  logic [23:0] base_freq, freq_word;
  logic [15:0] channel_spacing;
  rph_rx_byte_t rx_out;
  int errors, n_compared, ndone, n0;
  // ----------------------------------------
  // Tables: index, reset, write, readback; ctrl1, address, length, accepted; debug write, pin
  // ----------------------------------------
  localparam logic [39:0] REGS [9] = '{40'hdf00_d3a5_a5, 40'hdf01_915a_5a, 40'hdf02_ff05_05,
    40'hdf03_04ff_e7, 40'hdf04_45f7_77, 40'hdf05_005a_5a, 40'hdf06_0007_07, 40'hdf31_00ff_7f,
    40'hdf20_00ff_00};
  localparam logic [31:0] PKTS [11] = '{32'h075a_0301, 32'h0700_0301, 32'h07ff_0301,
    32'h0733_0300, 32'h06ff_0300, 32'h0600_0301, 32'h0500_0300, 32'h0433_0301, 32'h075a_0600,
    32'he75a_0300, 32'h035a_0301};
  localparam logic [15:0] DBG [7] = '{16'h7f01, 16'h3f00, 16'h0201, 16'h4200, 16'h0000, 16'h0101, 16'h4501};
  localparam logic [7:0] TXM [2] = '{8'h25, 8'h45};
  rph_packet_handler uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .rx_bit_valid(rx_bit_valid), .rx_bit(rx_bit), .rssi(rssi),
    .lqi(lqi), .rx_out(rx_out), .pkt_done(pkt_done), .crc_ok(crc_ok), .tx_start(tx_start),
    .tx_bit_req(tx_bit_req), .tx_data_bit(tx_data_bit), .tx_crc_sel(tx_crc_sel), .tx_bit(tx_bit),
    .base_freq(base_freq), .channel_spacing(channel_spacing), .freq_word(freq_word),
    .debug_port_pin(debug_port_pin));
  rph_air_model air (.hclk(hclk), .bit_valid(rx_bit_valid), .bit_out(rx_bit));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [15:0] crc16(input logic [31:0] v);
    logic [15:0] c;
    c = CRC_INIT;
    for (int i = 31; i >= 0; i--) begin
      c = {c[14:0], 1'b0} ^ ((v[i] ^ c[15]) ? CRC_POLY : 16'h0000);
    end
    return c;
  endfunction
  function automatic logic [47:0] pn_bits();
    logic [8:0] s;
    s = PN9_SEED;
    for (int i = 47; i >= 0; i--) begin
      pn_bits[i] = s[0];
      s = {s[5] ^ s[0], s[8:1]};
    end
  endfunction
  task automatic bus(input logic wr, input logic [15:0] idx, input logic [31:0] wd, output logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {idx, 2'b00};
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    d = hrdata;
  endtask
  task automatic pkt(input logic [7:0] ad, input logic [7:0] len);
    air.send({16'haaaa, 16'ha55a, len, ad, 40'h3c3c_3c3c_3c, 40'h0}, 48 + 8 * (int'(len) - 1));
    repeat (12) @(posedge hclk);
  endtask
  task automatic conclude();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge hclk) begin
    if (rx_out.valid === 1'b1) begin
      prev <= last;
      last <= rx_out.data;
    end
    if (pkt_done === 1'b1) ndone <= ndone + 1;
  end
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  // The watchdog allows several times the expected run length.
  initial begin
    repeat (20000) @(posedge hclk);
    errors++;
    $display("[ERR] %0t timeout", $time);
    conclude();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {hresetn, hsel, hwrite, tx_start, tx_bit_req, tx_data_bit, tx_crc_sel} = '0;
    haddr = '0;
    htrans = 2'b00;
    hsize = 3'b010;
    hwdata = '0;
    rssi = 8'hc4;
    lqi = 7'h2b;
    base_freq = 24'h10_0000;
    channel_spacing = 16'h0100;
    {errors, n_compared, ndone, last, prev} = '0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    foreach (REGS[i]) begin
      bus(1'b0, REGS[i][39:24], 32'h0, rd);
      chk(rd, {24'h0, REGS[i][23:16]});
      bus(1'b1, REGS[i][39:24], {24'h0, REGS[i][15:8]}, rd);
      bus(1'b0, REGS[i][39:24], 32'h0, rd);
      chk(rd, {24'h0, REGS[i][7:0]});
    end
    chk({8'h0, freq_word}, 32'h0010_0700);
    // Whitening and the legacy check stay off together; CRC off reports a good packet.
    bus(1'b1, IDX_CTRL0, 32'h01, rd);
    foreach (PKTS[i]) begin
      bus(1'b1, IDX_CTRL1, {24'h0, PKTS[i][31:24]}, rd);
      n0 = ndone;
      pkt(PKTS[i][23:16], PKTS[i][15:8]);
      chk(ndone - n0, PKTS[i][7:0]);
      if (PKTS[i][0] && PKTS[i][26]) begin
        chk({24'h0, prev}, {24'h0, rssi});
        chk({24'h0, last}, {24'h1, lqi});
      end else if (PKTS[i][0]) begin
        chk({24'h0, last}, 32'h3c);
      end
    end
    // A whitened packet with a broken and then a valid checksum, then both transmit formats.
    txw = {32'h035a_3c3c, crc16(32'h035a_3c3c)};
    pn = pn_bits();
    bus(1'b1, IDX_CTRL0, 32'h45, rd);
    bus(1'b1, IDX_CTRL1, 32'h07, rd);
    for (int i = 1; i >= 0; i--) begin
      n0 = ndone;
      air.send({16'haaaa, 16'ha55a, txw ^ {32'h0, 16'(i)} ^ pn, 48'h0}, 80);
      repeat (12) @(posedge hclk);
      chk(ndone - n0, 32'h1);
      chk({24'h0, last}, {24'h0, ~i[0], lqi});
      chk({31'h0, crc_ok}, {31'h0, ~i[0]});
    end
    foreach (TXM[m]) begin
      bus(1'b1, IDX_CTRL0, {24'h0, TXM[m]}, rd);
      tx_start <= 1'b1;
      @(posedge hclk);
      tx_start <= 1'b0;
      for (int k = 0; k < 48; k++) begin
        tx_data_bit <= txw[47 - k];
        tx_crc_sel <= (k >= 32);
        tx_bit_req <= 1'b1;
        @(posedge hclk);
        tx_bit_req <= 1'b0;
        @(posedge hclk);
        chk({31'h0, tx_bit}, {31'h0, pn[47 - k] ^ (m == 1 && txw[47 - k])});
      end
    end
    foreach (DBG[i]) begin
      bus(1'b1, IDX_DEBUG0, {24'h0, DBG[i][15:8]}, rd);
      repeat (3) @(posedge hclk);
      chk({31'h0, debug_port_pin}, {31'h0, DBG[i][0]});
    end
    conclude();
  end
endmodule
